/* design/nibble_host_port_irq.sv */
// host port of the meter front end: nibble bus, registers, interrupt
// assumes host pins are asynchronous; measurement inputs are on ref_clk

module nibble_host_port_irq
    import nibble_port_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire host_pins_t pins,
    input wire meas_values_t meas_in,
    input wire logic [EV_N-1:0] meas_new,
    input wire logic [MISC2_RO_W-1:0] misc2_flags,
    output logic [3:0] nibble_bus_out,
    output logic nibble_bus_oe_n,
    output logic host_interrupt_n,
    output logic [CTRL_REGS-1:0][DATA_W-1:0] ctrl_r
);

    host_pins_t pins_s;
    logic wr_prev_r;
    logic rd_prev_r;
    logic cs_prev_r;
    logic [3:0] addr_r;
    logic [2:0] nibble_cycle_counter;
    logic [3:0] hold_r;
    logic [3:0] event_irq_enable_bits;
    logic [EV_N-1:0] event_status_bits;
    logic [WORD_W-1:0] snap_r;
    logic [3:0] bus_out_r;
    logic oe_n_r;
    logic irq_n_r;

    // host pins cross into ref_clk before anything reads them
    pin_sync #(
        .W($bits(host_pins_t)),
        .IDLE(PINS_IDLE)
    ) u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .pins(pins),
        .pins_s(pins_s)
    );

    // strobe edges; cs sampled a cycle late so a shared release counts
    wire cs_act = ~pins_s.cs_n;
    wire ale_s = pins_s.ale;
    wire wr_rise = pins_s.wr_n & ~wr_prev_r & cs_prev_r & ~ale_s;
    wire rd_rise = pins_s.rd_n & ~rd_prev_r & cs_prev_r & ~ale_s;
    wire rd_fall = ~pins_s.rd_n & rd_prev_r & cs_act;
    wire rd_active = ~pins_s.rd_n & cs_act;

    // address decode
    wire is_ctrl = addr_r <= ADDR_CTRL_LAST;
    wire is_irq = addr_r == ADDR_IRQ;
    wire [2:0] total = nib_total(addr_r);
    wire last_nib = nibble_cycle_counter == 3'(total - 3'h1);

    // write path: upper nibble held, byte written on second nibble
    wire wr_first = wr_rise & (nibble_cycle_counter == 3'h0);
    wire wr_commit = wr_rise & (nibble_cycle_counter == 3'h1);
    wire [DATA_W-1:0] wr_data = {hold_r, pins_s.bus};
    wire wr_ctrl = wr_commit & is_ctrl;
    wire wr_irq = wr_commit & is_irq;

    // read values; reserved bits of the flag field come from the pins
    wire [DATA_W-1:0] misc2_rd = {ctrl_r[ADDR_MISC2][7], misc2_flags,
                                  ctrl_r[ADDR_MISC2][3:0]};
    wire [DATA_W-1:0] irq_rd = {event_status_bits, event_irq_enable_bits};
    logic [WORD_W-1:0] live_word;

    always_comb begin
        case (addr_r)
            ADDR_MISC2: live_word = {16'h0000, misc2_rd};
            ADDR_IRQ: live_word = {16'h0000, irq_rd};
            ADDR_TB: live_word = meas_in.timebase;
            ADDR_SIG: live_word = meas_in.signal;
            ADDR_POS: live_word = {8'h00, meas_in.pos_peak};
            ADDR_NEG: live_word = {8'h00, meas_in.neg_peak};
            ADDR_FAST: live_word = {8'h00, meas_in.fast};
            ADDR_PREC: live_word = meas_in.precise;
            default: live_word = {16'h0000, ctrl_r[addr_r]};
        endcase
    end

    // later nibbles come from a copy taken at the first, so a value
    // that updates mid-read cannot tear across nibbles
    wire [WORD_W-1:0] rd_word = (nibble_cycle_counter == 3'h0) ? live_word : snap_r;
    wire [3:0] rd_nibble = nib_pick(rd_word, total, nibble_cycle_counter);

    // end of the last nibble read of a register
    wire last_rd = rd_rise & last_nib;
    wire stat_read_done = last_rd & is_irq;

    // which status bit a completed measurement read clears
    logic [EV_N-1:0] read_clear_strobe;

    always_comb begin
        read_clear_strobe = '0;
        if (last_rd) begin
            case (addr_r)
                ADDR_SIG: read_clear_strobe[EV_FREQ] = 1'b1;
                ADDR_POS: read_clear_strobe[EV_PEAK] = 1'b1;
                ADDR_NEG: read_clear_strobe[EV_PEAK] = 1'b1;
                ADDR_FAST: read_clear_strobe[EV_FAST] = 1'b1;
                ADDR_PREC: read_clear_strobe[EV_PREC] = 1'b1;
                default: read_clear_strobe = '0;
            endcase
        end
    end

    event_status #(
        .N(EV_N)
    ) u_status (
        .ref_clk(ref_clk),
        .reset(reset),
        .set_ev(meas_new),
        .clr_ev(read_clear_strobe),
        .status_r(event_status_bits)
    );

    // interrupt: a new enabled event wins over the status read,
    // so the line stays low and the host must read again
    wire new_enabled = |(meas_new & event_irq_enable_bits);
    wire irq_n_nxt = ~new_enabled & (irq_n_r | stat_read_done);

    // strobe history; resets to idle pin levels so that leaving reset
    // never shows a false strobe edge
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_prev_r <= 1'b1;
            rd_prev_r <= 1'b1;
            cs_prev_r <= 1'b0;
        end else begin
            wr_prev_r <= pins_s.wr_n;
            rd_prev_r <= pins_s.rd_n;
            cs_prev_r <= cs_act;
        end
    end

    // address capture and nibble position; the counter saturates
    // instead of wrapping, so an over-long read returns zeros rather
    // than starting the value again
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            addr_r <= 4'h0;
            nibble_cycle_counter <= 3'h0;
        end else if (ale_s) begin
            addr_r <= pins_s.bus;
            nibble_cycle_counter <= 3'h0;
        end else if ((wr_rise | rd_rise) && nibble_cycle_counter != NIB_MAX) begin
            nibble_cycle_counter <= nibble_cycle_counter + 3'h1;
        end
    end

    // write holding nibble and read copy
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hold_r <= 4'h0;
            snap_r <= '0;
        end else begin
            if (wr_first) begin
                hold_r <= pins_s.bus;
            end
            if (rd_fall && nibble_cycle_counter == 3'h0) begin
                snap_r <= live_word;
            end
        end
    end

    // control registers; writes above the interrupt register fall away
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl_r <= {CTRL_REGS{CTRL_RESET}};
            event_irq_enable_bits <= EN_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_r[addr_r] <= wr_data;
            end
            if (wr_irq) begin
                event_irq_enable_bits <= wr_data[3:0];
            end
        end
    end

    // pin drivers; registered, so read data reaches the host three edges
    // after its strobe falls, traded for glitch-free outputs
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            bus_out_r <= 4'h0;
            oe_n_r <= 1'b1;
            irq_n_r <= 1'b1;
        end else begin
            bus_out_r <= rd_nibble;
            oe_n_r <= ~rd_active;
            irq_n_r <= irq_n_nxt;
        end
    end

    assign nibble_bus_out = bus_out_r;
    assign nibble_bus_oe_n = oe_n_r;
    assign host_interrupt_n = irq_n_r;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    irq_falls_a: assert property (new_enabled |=> !host_interrupt_n)
        else $error("enabled event did not pull interrupt low");

    irq_release_a: assert property (
        stat_read_done && !new_enabled |=> host_interrupt_n)
        else $error("interrupt not released after status read");

    irq_holds_a: assert property (
        !host_interrupt_n && !stat_read_done |=> !host_interrupt_n)
        else $error("interrupt released without status read");

    property ctrl_write_p;
        logic [3:0] a;
        logic [7:0] d;
        (wr_ctrl, a = addr_r, d = wr_data) |=> ctrl_r[a] == d;
    endproperty
    ctrl_write_a: assert property (ctrl_write_p)
        else $error("control write lost");

    meas_write_a: assert property (
        wr_commit && addr_r >= ADDR_TB |=> $stable(ctrl_r) && $stable(event_irq_enable_bits))
        else $error("write to measurement address had effect");

    ale_clear_a: assert property (ale_s |=> nibble_cycle_counter == 3'h0)
        else $error("nibble counter not cleared by address strobe");

    reset_zero_a: assert property (@(posedge ref_clk) disable iff (1'b0)
        reset |=> ctrl_r == '0)
        else $error("control registers not cleared by reset");

    status_any_a: assert property (
        meas_new != '0 |=> (event_status_bits & $past(meas_new)) == $past(meas_new))
        else $error("status bit not set regardless of enable");

    tb_keep_a: assert property (
        last_rd && addr_r == ADDR_TB && event_status_bits[EV_FREQ]
        |=> event_status_bits[EV_FREQ])
        else $error("timebase read cleared counter status");

    sig_clear_a: assert property (
        rd_rise && addr_r == ADDR_SIG && nibble_cycle_counter == 3'h5
        && !meas_new[EV_FREQ] |=> !event_status_bits[EV_FREQ])
        else $error("sixth signal read did not clear counter status");

    fast_clear_a: assert property (
        rd_rise && addr_r == ADDR_FAST && nibble_cycle_counter == 3'h3
        && !meas_new[EV_FAST] |=> !event_status_bits[EV_FAST])
        else $error("fourth fast read did not clear status");

    peak_clear_a: assert property (
        last_rd && (addr_r == ADDR_POS || addr_r == ADDR_NEG)
        && !meas_new[EV_PEAK] |=> !event_status_bits[EV_PEAK])
        else $error("peak read did not clear peak status");

    upper_first_a: assert property (
        rd_fall && nibble_cycle_counter == 3'h0 && addr_r <= ADDR_IRQ
        |=> nibble_bus_out == $past(live_word[7:4]))
        else $error("first nibble is not the upper one");

    drive_read_a: assert property (rd_active |=> !nibble_bus_oe_n ##1 1'b1)
        else $error("bus not driven during read");

    // register, counter and pin guards
    ctrl_only_wr_a: assert property (!wr_ctrl |=> $stable(ctrl_r))
        else $error("control register changed without a write");

    en_write_a: assert property (
        wr_irq |=> event_irq_enable_bits == $past(wr_data[3:0]))
        else $error("enable bits not written");

    status_ro_a: assert property (
        wr_irq && meas_new == '0 && read_clear_strobe == '0
        |=> $stable(event_status_bits))
        else $error("status bits changed by a write");

    extra_wr_a: assert property (
        wr_rise && nibble_cycle_counter >= 3'h2
        |=> $stable(ctrl_r) && $stable(event_irq_enable_bits))
        else $error("nibble past the second changed a register");

    addr_take_a: assert property (ale_s |=> addr_r == $past(pins_s.bus))
        else $error("address not taken under the strobe");

    oe_release_a: assert property (!rd_active |=> nibble_bus_oe_n)
        else $error("bus driven outside a read");

    lower_second_a: assert property (
        rd_active && nibble_cycle_counter == 3'h1 && addr_r <= ADDR_IRQ
        |=> nibble_bus_out == $past(snap_r[3:0]))
        else $error("second nibble is not the lower one");

    count_hold_a: assert property (
        !ale_s && !wr_rise && !rd_rise |=> $stable(nibble_cycle_counter))
        else $error("nibble counter moved without a strobe");

    count_sat_a: assert property (
        nibble_cycle_counter == NIB_MAX && !ale_s |=> nibble_cycle_counter == NIB_MAX)
        else $error("nibble counter wrapped");

    past_width_a: assert property (
        rd_active && nibble_cycle_counter >= total |=> nibble_bus_out == 4'h0)
        else $error("read past the register width not zero");

    irq_quiet_a: assert property (
        host_interrupt_n && !new_enabled |=> host_interrupt_n)
        else $error("interrupt fell without an enabled event");

    prec_clear_a: assert property (
        last_rd && addr_r == ADDR_PREC && !meas_new[EV_PREC]
        |=> !event_status_bits[EV_PREC])
        else $error("precise read did not clear status");

    irq_seen_c: cover property (!host_interrupt_n ##[1:50] host_interrupt_n);
    long_read_c: cover property (last_rd && addr_r == ADDR_PREC);
    ctrl_wr_c: cover property (wr_ctrl);
    reread_c: cover property (stat_read_done && new_enabled);
    restart_c: cover property (wr_first ##[1:100] ale_s);

endmodule

/* inc/nibble_port_pkg.sv */
// constants, carriers and helpers shared by the nibble host port
// assumes one clock domain and a host that strobes the nibble bus

package nibble_port_pkg;

    localparam int NIB_W = 4;
    localparam int DATA_W = 8;
    localparam int WORD_W = 24;
    localparam int EV_N = 4;
    localparam int CTRL_REGS = 9;

    // register map
    localparam logic [3:0] ADDR_CTRL_LAST = 4'h8;
    localparam logic [3:0] ADDR_MISC2 = 4'h8;
    localparam logic [3:0] ADDR_IRQ = 4'h9;
    localparam logic [3:0] ADDR_TB = 4'ha;
    localparam logic [3:0] ADDR_SIG = 4'hb;
    localparam logic [3:0] ADDR_POS = 4'hc;
    localparam logic [3:0] ADDR_NEG = 4'hd;
    localparam logic [3:0] ADDR_FAST = 4'he;
    localparam logic [3:0] ADDR_PREC = 4'hf;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [3:0] EN_RESET = 4'h0;

    // nibble transfers per register width
    localparam logic [2:0] NIB_REG = 3'h2;
    localparam logic [2:0] NIB_SHORT = 3'h4;
    localparam logic [2:0] NIB_LONG = 3'h6;
    localparam logic [2:0] NIB_MAX = 3'h7;

    // event bit positions
    localparam int EV_FREQ = 3;
    localparam int EV_PEAK = 2;
    localparam int EV_FAST = 1;
    localparam int EV_PREC = 0;

    // read-only flag field of the buzzer/detector register
    localparam int MISC2_RO_LSB = 4;
    localparam int MISC2_RO_W = 3;

    typedef struct packed {
        logic cs_n;
        logic wr_n;
        logic rd_n;
        logic ale;
        logic [3:0] bus;
    } host_pins_t;

    localparam host_pins_t PINS_IDLE = '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1,
                                         ale: 1'b0, bus: 4'h0};

    typedef struct packed {
        logic [23:0] timebase;
        logic [23:0] signal;
        logic [15:0] pos_peak;
        logic [15:0] neg_peak;
        logic [15:0] fast;
        logic [23:0] precise;
    } meas_values_t;

    // nibble reads that one full value of a register takes
    function automatic logic [2:0] nib_total(input logic [3:0] a);
        if (a == ADDR_TB || a == ADDR_SIG || a == ADDR_PREC) begin
            nib_total = NIB_LONG;
        end else if (a >= ADDR_POS) begin
            nib_total = NIB_SHORT;
        end else begin
            nib_total = NIB_REG;
        end
    endfunction

    // nibble idx of a value, most significant first
    function automatic logic [3:0] nib_pick(input logic [23:0] w,
                                            input logic [2:0] total,
                                            input logic [2:0] idx);
        logic [2:0] k;
        k = 3'(total - idx - 3'h1);
        if (idx >= total) begin
            nib_pick = 4'h0;
        end else begin
            nib_pick = w[{k, 2'b00} +: 4];
        end
    endfunction

endpackage

/* design/pin_sync.sv */
// two-stage synchroniser for a group of host pins
// assumes the pins are asynchronous to ref_clk

module pin_sync
    import nibble_port_pkg::*;
#(
    parameter int W = 8,
    parameter logic [W-1:0] IDLE = '0
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [W-1:0] pins,
    output logic [W-1:0] pins_s
);

    logic [W-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_r <= IDLE;
            pins_s <= IDLE;
        end else begin
            meta_r <= pins;
            pins_s <= meta_r;
        end
    end

endmodule

/* design/event_status.sv */
// sticky event status bits, set by new measurements, cleared by reads
// assumes set and clear are one-cycle pulses on ref_clk

module event_status
    import nibble_port_pkg::*;
#(
    parameter int N = EV_N
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [N-1:0] set_ev,
    input wire logic [N-1:0] clr_ev,
    output logic [N-1:0] status_r
);

    logic [N-1:0] status_nxt;

    // a set in the clearing cycle wins, so no event is lost
    assign status_nxt = set_ev | (status_r & ~clr_ev);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            status_r <= '0;
        end else begin
            status_r <= status_nxt;
        end
    end

    set_wins_a: assert property (@(posedge ref_clk) disable iff (reset)
        (set_ev != '0) |=> ((status_r & $past(set_ev)) == $past(set_ev)))
        else $error("event lost against a clear");

    clear_works_a: assert property (@(posedge ref_clk) disable iff (reset)
        (clr_ev != '0) && (set_ev == '0) |=> ((status_r & $past(clr_ev)) == '0))
        else $error("status bit not cleared");

endmodule

/* test/host_model.sv */
// host side model: strobes the nibble bus of the port
// assumes a 10 MHz ref_clk and a device answering within 3 edges
module host_model
    import nibble_port_pkg::*;
#(
    parameter int RD_LOW = 21,
    parameter int SAMPLE_CYC = 40
) (
    input wire logic ref_clk,
    input wire logic [3:0] nibble_bus_out,
    input wire logic nibble_bus_oe_n,
    input wire logic host_interrupt_n,
    output host_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ns;
    logic cs_n = 1'b1;
    logic wr_n = 1'b1;
    logic rd_n = 1'b1;
    logic ale = 1'b0;
    logic drv_en = 1'b1;
    logic [3:0] drv = 4'h0;
    logic [3:0] last_r = 4'h0;
    logic [3:0] wire_v;
    // wire level; a released bus toggles so stale data cannot pass
    assign wire_v = !nibble_bus_oe_n ? nibble_bus_out : (drv_en ? drv : ~last_r);
    assign pins = '{cs_n: cs_n, wr_n: wr_n, rd_n: rd_n, ale: ale, bus: wire_v};
    always @(posedge ref_clk) begin
        last_r <= wire_v;
    end
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // select, present the address under the latch strobe
    task automatic addr(input logic [3:0] a);
        @(posedge ref_clk);
        cs_n <= 1'b0;
        ale <= 1'b1;
        drv_en <= 1'b1;
        drv <= a;
        step(4);
        ale <= 1'b0;
        step(4);
    endtask
    task automatic wr_nib(input logic [3:0] d);
        drv <= d;
        wr_n <= 1'b0;
        step(4);
        wr_n <= 1'b1; // taken on this rise
        step(4);
    endtask
    // bus released while strobe low; sampled just before the rise
    task automatic rd_nib(input int low, output logic [3:0] d);
        rd_n <= 1'b0;
        drv_en <= 1'b0;
        step(low);
        d = wire_v;
        rd_n <= 1'b1;
        step(4);
    endtask
    task automatic done();
        cs_n <= 1'b1;
        step(4);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        addr(a);
        wr_nib(v[7:4]);
        wr_nib(v[3:0]);
        done();
    endtask
    // exactly n nibbles, msb first; converter reads stretch the first
    task automatic rd_reg(input logic [3:0] a, input int n, output logic [23:0] v);
        logic [3:0] d;
        v = 24'h0;
        addr(a);
        for (int i = 0; i < n; i++) begin
            rd_nib((i == 0 && a >= ADDR_FAST) ? SAMPLE_CYC : RD_LOW, d);
            v = {v[19:0], d};
        end
        done();
    endtask
    // an edge may be missed during the read, so read once more if still low
    task automatic service(output logic [7:0] s);
        logic [23:0] v;
        rd_reg(ADDR_IRQ, 2, v);
        if (host_interrupt_n === 1'b0) begin
            rd_reg(ADDR_IRQ, 2, v);
        end
        s = v[7:0];
    endtask
endmodule

/* test/tb_top.sv */
// testbench: registers, measurement reads and interrupt of the port
// assumes host_model on the pins and one 10 MHz clock
module tb_top
    import nibble_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    host_pins_t pins;
    meas_values_t meas_in = '{24'h123456, 24'h789abc, 16'hdef0, 16'h2468, 16'h9bdf, 24'hfedcb9};
    logic [EV_N-1:0] meas_new = '0;
    logic [MISC2_RO_W-1:0] misc2_flags = 3'h5;
    logic [3:0] bus_out;
    logic oe_n;
    logic irq_n;
    logic [CTRL_REGS-1:0][DATA_W-1:0] ctrl;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [23:0] v;
    logic [7:0] s;
    logic [3:0] d4;
    // expected values and nibble counts per measurement address
    logic [23:0] exp_m [6] = '{24'h123456, 24'h789abc, 24'hdef0, 24'h2468, 24'h9bdf, 24'hfedcb9};
    int nib_m [6] = '{6, 6, 4, 4, 4, 6};
    logic [3:0] clr_a [4] = '{ADDR_PREC, ADDR_FAST, ADDR_NEG, ADDR_SIG};
    int nib_c [4] = '{6, 4, 4, 6};
    always #50 ref_clk = ~ref_clk;
    nibble_host_port_irq dut_u (
        .ref_clk(ref_clk),
        .reset(reset),
        .pins(pins),
        .meas_in(meas_in),
        .meas_new(meas_new),
        .misc2_flags(misc2_flags),
        .nibble_bus_out(bus_out),
        .nibble_bus_oe_n(oe_n),
        .host_interrupt_n(irq_n),
        .ctrl_r(ctrl)
    );
    host_model host_u (
        .ref_clk(ref_clk),
        .nibble_bus_out(bus_out),
        .nibble_bus_oe_n(oe_n),
        .host_interrupt_n(irq_n),
        .pins(pins)
    );
    task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask
    // settle past the edge so registered pins are seen updated
    task automatic check_pin(input logic got, input logic exp);
        #1;
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: pin %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one-cycle new-value pulse, then let the line settle
    task automatic pulse(input int i);
        @(posedge ref_clk);
        meas_new <= 4'(1 << i);
        @(posedge ref_clk);
        meas_new <= '0;
        repeat (3) @(posedge ref_clk);
    endtask
    // hang guard, well above the few thousand cycles the tests need
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            failures++;
            $display("CHECK FAILED at %0t: timeout", $time);
            summarize();
        end
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        // reset values; 08 bits 6:4 show the flag inputs
        for (int i = 0; i <= CTRL_REGS; i++) begin
            host_u.rd_reg(4'(i), 2, v);
            check_val(v, (i == 8) ? 24'h50 : 24'h0);
        end
        $display("test reset_values done");
        // distinct bytes so a nibble swap shows in every register but 06, whose cc reads the same swapped
        for (int i = 0; i < CTRL_REGS; i++) begin
            host_u.wr_reg(4'(i), 8'(8'h5a + 8'h13 * i));
        end
        for (int i = 0; i < CTRL_REGS; i++) begin
            host_u.rd_reg(4'(i), 2, v);
            check_val(v, (i == 8) ? 24'hd2 : 24'(8'(8'h5a + 8'h13 * i)));
            check_val(24'(ctrl[i]), 24'(8'(8'h5a + 8'h13 * i)));
        end
        $display("test ctrl_rw done");
        // half a write, then a fresh address restarts at the upper nibble
        host_u.addr(4'h0);
        host_u.wr_nib(4'h1);
        host_u.addr(4'h1);
        host_u.wr_nib(4'hc);
        host_u.wr_nib(4'h3);
        host_u.done();
        check_val(24'(ctrl[0]), 24'h5a);
        check_val(24'(ctrl[1]), 24'hc3);
        host_u.addr(4'h1);
        host_u.rd_nib(21, d4);
        host_u.done();
        check_val(24'(d4), 24'hc);
        host_u.rd_reg(4'h1, 2, v);
        check_val(v, 24'hc3);
        $display("test ale_restart done");
        // writes to measurement places are ignored
        for (int k = 0; k < 6; k++) begin
            host_u.wr_reg(4'(ADDR_TB + k), 8'h00);
            host_u.rd_reg(4'(ADDR_TB + k), nib_m[k], v);
            check_val(v, exp_m[k]);
        end
        check_val(24'(ctrl[2]), 24'h80);
        $display("test measurements done");
        // a value replaced during a read comes out whole; flags follow pins
        misc2_flags <= 3'h2;
        host_u.addr(ADDR_PREC);
        host_u.rd_nib(40, d4);
        v = {20'h0, d4};
        meas_in.precise <= 24'h0a1b2c;
        for (int k = 1; k < 6; k++) begin
            host_u.rd_nib(21, d4);
            v = {v[19:0], d4};
        end
        host_u.done();
        check_val(v, 24'hfedcb9);
        host_u.rd_reg(ADDR_PREC, 6, v);
        check_val(v, 24'h0a1b2c);
        host_u.rd_reg(ADDR_MISC2, 2, v);
        check_val(v, 24'ha2);
        $display("test snapshot done");
        // status field read-only; events set status with enables off
        host_u.wr_reg(ADDR_IRQ, 8'hf0);
        host_u.rd_reg(ADDR_IRQ, 2, v);
        check_val(v, 24'h0);
        for (int i = 0; i < EV_N; i++) begin
            pulse(i);
            check_pin(irq_n, 1'b1);
            host_u.rd_reg(ADDR_IRQ, 2, v);
            check_val(v, 24'(8'h10 << i));
            if (i == EV_FREQ) begin
                host_u.rd_reg(ADDR_TB, 6, v);
                host_u.rd_reg(ADDR_IRQ, 2, v);
                check_val(v, 24'h80);
            end
            host_u.rd_reg(clr_a[i], nib_c[i], v);
            host_u.rd_reg(ADDR_IRQ, 2, v);
            check_val(v, 24'h0);
        end
        $display("test status_clear done");
        // only enabled events pull the line, held until serviced
        host_u.wr_reg(ADDR_IRQ, 8'h05);
        pulse(EV_FAST);
        check_pin(irq_n, 1'b1);
        pulse(EV_PREC);
        check_pin(irq_n, 1'b0);
        repeat (30) @(posedge ref_clk);
        check_pin(irq_n, 1'b0);
        host_u.service(s);
        check_val(24'(s), 24'h35);
        check_pin(irq_n, 1'b1);
        $display("test interrupt done");
        // an enabled event in the status-read release cycle pulls the already released line low again
        fork
            host_u.service(s);
            begin
                repeat (56) @(posedge ref_clk);
                pulse(EV_PREC);
            end
        join
        check_val(24'(s), 24'h35);
        check_pin(irq_n, 1'b1);
        $display("test reread done");
        // chip reset in mid-run clears every written control register
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        for (int i = 0; i < CTRL_REGS; i++) begin
            check_val(24'(ctrl[i]), 24'h0);
        end
        host_u.rd_reg(ADDR_MISC2, 2, v);
        check_val(v, 24'h20);
        $display("test mid_reset done");
        summarize();
    end
endmodule
